// *** logic/ahpc_regs.sv ***
/*
  Register bank holding the left and right record high-pass coefficients,
  plus a reserved range that reads zero.
  Assumes a same-clock register port from the control bus front end, with
  page selection already resolved outside.
*/
`timescale 1ns/1ps
`include "ahpc_map.svh"

// Summary of operation
// - Addresses 0x37 to 0x40 read zero and ignore writes; the controller must not write them.
// - Each coefficient is upper byte over lower byte as one signed 16-bit value.
// - Left first numerator sits at 0x41/0x42 with reset 0x39/0x55.
// - Left second numerator sits at 0x43/0x44 with reset 0xF3/0x2D.
// - Left denominator sits at 0x45/0x46 with reset 0x53/0x7E.
// - Right first numerator sits at 0x47/0x48 with reset 0x39/0x55.
// - Right second numerator upper byte sits at 0x49, all bits writable, reset 0xF3.
// - Right second numerator lower byte sits at 0x4A with reset 0x2D.
// - Right denominator sits at 0x4B/0x4C with reset 0x53/0x7E.
module ahpc_regs (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  output ahpc_pkg::ahpc_coef_t left_first_numerator_coef,
  output ahpc_pkg::ahpc_coef_t left_second_numerator_coef,
  output ahpc_pkg::ahpc_coef_t left_denominator_coef,
  output ahpc_pkg::ahpc_coef_t right_first_numerator_coef,
  output ahpc_pkg::ahpc_coef_t right_second_numerator_coef,
  output ahpc_pkg::ahpc_coef_t right_denominator_coef
);
  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic ahpc_pkg::ahpc_hit_e classify(input logic [7:0] addr);
    if (addr >= `AHPC_COEF_FIRST && addr <= `AHPC_COEF_LAST) begin
      return ahpc_pkg::AHPC_HIT_COEF;
    end else if (addr >= `AHPC_RSVD_FIRST && addr <= `AHPC_RSVD_LAST) begin
      return ahpc_pkg::AHPC_HIT_RSVD;
    end else begin
      return ahpc_pkg::AHPC_HIT_NONE;
    end
  endfunction

  function automatic logic [3:0] byte_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - `AHPC_COEF_FIRST;
    return diff[3:0];
  endfunction

  function automatic logic [7:0] reset_value(input int idx);
    logic [7:0] val;
    val = 8'h00;
    unique case (idx % 6)
      0: val = `AHPC_RST_NUM0_HI;
      1: val = `AHPC_RST_NUM0_LO;
      2: val = `AHPC_RST_NUM1_HI;
      3: val = `AHPC_RST_NUM1_LO;
      4: val = `AHPC_RST_DEN1_HI;
      5: val = `AHPC_RST_DEN1_LO;
    endcase
    return val;
  endfunction

  // ----------------------------------------
  // Coefficient storage
  // ----------------------------------------
  logic [7:0] store [`AHPC_NUM_BYTES];
  logic [7:0] next_store [`AHPC_NUM_BYTES];
  ahpc_pkg::ahpc_hit_e wr_hit;
  ahpc_pkg::ahpc_hit_e rd_hit;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;

  assign wr_hit = classify(reg_addr);
  assign rd_hit = wr_hit;
  assign wr_idx = byte_index(reg_addr);
  assign rd_idx = wr_idx;

  always_comb begin
    for (int i = 0; i < `AHPC_NUM_BYTES; i++) begin
      next_store[i] = store[i];
    end
    if (reg_wr && wr_hit == ahpc_pkg::AHPC_HIT_COEF) begin
      next_store[wr_idx] = reg_wdata;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `AHPC_NUM_BYTES; gi++) begin : g_store
      localparam logic [7:0] SLOT_DEFAULT = reset_value(gi);
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          store[gi] <= SLOT_DEFAULT;
        end else begin
          store[gi] <= next_store[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] next_rdata;
  logic next_hit;

  always_comb begin
    next_rdata = reg_rdata;
    next_hit = 1'b0;
    if (reg_rd) begin
      next_hit = (rd_hit != ahpc_pkg::AHPC_HIT_NONE);
      unique case (rd_hit)
        ahpc_pkg::AHPC_HIT_COEF: next_rdata = store[rd_idx];
        ahpc_pkg::AHPC_HIT_RSVD: next_rdata = `AHPC_RSVD_VALUE;
        ahpc_pkg::AHPC_HIT_NONE: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_hit <= next_hit;
    end
  end

  // ----------------------------------------
  // Coefficient outputs
  // ----------------------------------------
  ahpc_if link ();

  generate
    for (gi = 0; gi < `AHPC_NUM_COEFS; gi++) begin : g_pair
      assign link.hi_byte[gi] = store[2 * gi];
      assign link.lo_byte[gi] = store[2 * gi + 1];
    end
  endgenerate

  ahpc_coef_join u_join (
    .link(link)
  );

  assign left_first_numerator_coef = link.coef[0];
  assign left_second_numerator_coef = link.coef[1];
  assign left_denominator_coef = link.coef[2];
  assign right_first_numerator_coef = link.coef[3];
  assign right_second_numerator_coef = link.coef[4];
  assign right_denominator_coef = link.coef[5];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_coef_write(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  sequence s_same_read(logic [7:0] a);
    reg_rd && !reg_wr && reg_addr == a;
  endsequence

  sequence s_reset_release;
    $rose(reset_n);
  endsequence

  a_rsvd_reads_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reg_rd && reg_addr >= `AHPC_RSVD_FIRST && reg_addr <= `AHPC_RSVD_LAST
    |=> reg_rdata == 8'h00 && reg_hit)
    else $error("reserved read not zero");

  a_coef_pair_join: assert property (@(posedge ref_clk) disable iff (!reset_n)
    left_denominator_coef == ahpc_pkg::ahpc_coef_t'({store[4], store[5]}))
    else $error("coefficient pairing wrong");

  a_left_num0_reset: assert property (@(posedge ref_clk)
    $rose(reset_n) |-> $past(left_first_numerator_coef) == 16'h3955)
    else $error("left first numerator reset wrong");

  a_left_num1_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_L_NUM1_LO) |=> left_second_numerator_coef[7:0] == $past(reg_wdata))
    else $error("left second numerator low byte not stored");

  a_left_den_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_L_DEN1_HI) |=> left_denominator_coef[15:8] == $past(reg_wdata))
    else $error("left denominator high byte not stored");

  a_right_num0_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_R_NUM0_LO) |=> right_first_numerator_coef[7:0] == $past(reg_wdata))
    else $error("right first numerator low byte not stored");

  a_right_num1_hi: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_R_NUM1_HI) |=> right_second_numerator_coef[15:8] == $past(reg_wdata))
    else $error("right second numerator high byte not stored");

  a_right_num1_lo: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_R_NUM1_LO) |=> right_second_numerator_coef[7:0] == $past(reg_wdata))
    else $error("right second numerator low byte not stored");

  a_right_den_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_R_DEN1_LO) |=> right_denominator_coef[7:0] == $past(reg_wdata))
    else $error("right denominator low byte not stored");

  a_write_read_back: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_L_NUM0_HI) ##1 s_same_read(`AHPC_L_NUM0_HI)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("read back differs from write");

  // ----------------------------------------
  // Write checks, remaining bytes
  // ----------------------------------------
  a_left_num0_hi: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_L_NUM0_HI) |=> left_first_numerator_coef[15:8] == $past(reg_wdata))
    else $error("left first numerator high byte not stored");

  a_left_num0_lo: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_L_NUM0_LO) |=> left_first_numerator_coef[7:0] == $past(reg_wdata))
    else $error("left first numerator low byte not stored");

  a_left_num1_hi: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_L_NUM1_HI) |=> left_second_numerator_coef[15:8] == $past(reg_wdata))
    else $error("left second numerator high byte not stored");

  a_left_den_lo: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_L_DEN1_LO) |=> left_denominator_coef[7:0] == $past(reg_wdata))
    else $error("left denominator low byte not stored");

  a_right_num0_hi: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_R_NUM0_HI) |=> right_first_numerator_coef[15:8] == $past(reg_wdata))
    else $error("right first numerator high byte not stored");

  a_right_den_hi: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_coef_write(`AHPC_R_DEN1_HI) |=> right_denominator_coef[15:8] == $past(reg_wdata))
    else $error("right denominator high byte not stored");

  // ----------------------------------------
  // Reset defaults
  // ----------------------------------------
  a_left_num1_reset: assert property (@(posedge ref_clk)
    s_reset_release |->
      $past(left_second_numerator_coef) == {`AHPC_RST_NUM1_HI, `AHPC_RST_NUM1_LO})
    else $error("left second numerator reset wrong");

  a_left_den_reset: assert property (@(posedge ref_clk)
    s_reset_release |->
      $past(left_denominator_coef) == {`AHPC_RST_DEN1_HI, `AHPC_RST_DEN1_LO})
    else $error("left denominator reset wrong");

  a_right_num0_reset: assert property (@(posedge ref_clk)
    s_reset_release |->
      $past(right_first_numerator_coef) == {`AHPC_RST_NUM0_HI, `AHPC_RST_NUM0_LO})
    else $error("right first numerator reset wrong");

  a_right_num1_reset: assert property (@(posedge ref_clk)
    s_reset_release |->
      $past(right_second_numerator_coef) == {`AHPC_RST_NUM1_HI, `AHPC_RST_NUM1_LO})
    else $error("right second numerator reset wrong");

  a_right_den_reset: assert property (@(posedge ref_clk)
    s_reset_release |->
      $past(right_denominator_coef) == {`AHPC_RST_DEN1_HI, `AHPC_RST_DEN1_LO})
    else $error("right denominator reset wrong");

  // ----------------------------------------
  // Read and hold checks
  // ----------------------------------------
  a_hit_one_cycle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !reg_rd |=> !reg_hit)
    else $error("decode indication without a read");

  a_coef_read_hit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reg_rd && classify(reg_addr) == ahpc_pkg::AHPC_HIT_COEF |=> reg_hit)
    else $error("coefficient read not flagged");

  a_unmapped_reads_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reg_rd && classify(reg_addr) == ahpc_pkg::AHPC_HIT_NONE
    |=> reg_rdata == 8'h00 && !reg_hit)
    else $error("unmapped read not zero");

  a_rdata_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_idle_coef_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !reg_wr |=> $stable(left_first_numerator_coef) && $stable(left_second_numerator_coef)
      && $stable(left_denominator_coef) && $stable(right_first_numerator_coef)
      && $stable(right_second_numerator_coef) && $stable(right_denominator_coef))
    else $error("coefficient changed without a write");

  a_stray_write_kept: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reg_wr && classify(reg_addr) != ahpc_pkg::AHPC_HIT_COEF
    |=> $stable(left_first_numerator_coef) && $stable(left_second_numerator_coef)
      && $stable(left_denominator_coef) && $stable(right_first_numerator_coef)
      && $stable(right_second_numerator_coef) && $stable(right_denominator_coef))
    else $error("write outside the bank changed a coefficient");

endmodule

// *** logic/ahpc_map.svh ***
/*
  Register addresses, reset values and sizes of the record-path high-pass
  coefficient bank. Assumes an 8-bit address space on one register page.
*/
`ifndef AHPC_MAP_SVH
`define AHPC_MAP_SVH

`define AHPC_RSVD_FIRST 8'h37
`define AHPC_RSVD_LAST 8'h40
`define AHPC_COEF_FIRST 8'h41
`define AHPC_COEF_LAST 8'h4C
`define AHPC_NUM_BYTES 12
`define AHPC_NUM_COEFS 6

`define AHPC_L_NUM0_HI 8'h41
`define AHPC_L_NUM0_LO 8'h42
`define AHPC_L_NUM1_HI 8'h43
`define AHPC_L_NUM1_LO 8'h44
`define AHPC_L_DEN1_HI 8'h45
`define AHPC_L_DEN1_LO 8'h46
`define AHPC_R_NUM0_HI 8'h47
`define AHPC_R_NUM0_LO 8'h48
`define AHPC_R_NUM1_HI 8'h49
`define AHPC_R_NUM1_LO 8'h4A
`define AHPC_R_DEN1_HI 8'h4B
`define AHPC_R_DEN1_LO 8'h4C

`define AHPC_RST_NUM0_HI 8'h39
`define AHPC_RST_NUM0_LO 8'h55
`define AHPC_RST_NUM1_HI 8'hF3
`define AHPC_RST_NUM1_LO 8'h2D
`define AHPC_RST_DEN1_HI 8'h53
`define AHPC_RST_DEN1_LO 8'h7E
`define AHPC_RSVD_VALUE 8'h00

`endif

// *** logic/ahpc_pkg.sv ***
/*
  Types shared by the coefficient bank modules.
  Assumes the map header supplies all numeric constants.
*/
package ahpc_pkg;
  typedef logic [7:0] ahpc_byte_t;
  typedef logic signed [15:0] ahpc_coef_t;
  typedef enum logic [1:0] {
    AHPC_HIT_NONE,
    AHPC_HIT_RSVD,
    AHPC_HIT_COEF
  } ahpc_hit_e;
endpackage

// *** logic/ahpc_if.sv ***
/*
  Carrier between the bank and its byte-pair combiner.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface ahpc_if;
  logic [7:0] hi_byte [6];
  logic [7:0] lo_byte [6];
  ahpc_pkg::ahpc_coef_t coef [6];
  modport bank (output hi_byte, output lo_byte, input coef);
  modport join_side (input hi_byte, input lo_byte, output coef);
endinterface

// *** logic/ahpc_coef_join.sv ***
/*
  Forms the six signed coefficients from their upper and lower bytes.
  Assumes the bank holds the bytes in registers.
*/
`timescale 1ns/1ps
module ahpc_coef_join (
  ahpc_if.join_side link
);
  // ----------------------------------------
  // Byte pairing
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_join
      assign link.coef[gi] = ahpc_pkg::ahpc_coef_t'({link.hi_byte[gi], link.lo_byte[gi]});
    end
  endgenerate
endmodule

// *** sim/ahpc_ctrl_model.sv ***
/*
  Controller model that drives the register port of the coefficient bank.
  Assumes one clock and that the bench calls its tasks only after reset.
*/
`timescale 1ns/1ps
`include "ahpc_map.svh"
module ahpc_ctrl_model (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a >= `AHPC_RSVD_FIRST && a <= `AHPC_RSVD_LAST) return;
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    h = reg_hit;
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = wd;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_wdata = ~wd;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

// *** sim/ahpc_regs_tb.sv ***
/*
  Self-checking bench for the coefficient bank with a byte-array model.
  Assumes the controller model drives the register port.
*/
`timescale 1ns/1ps
`include "ahpc_map.svh"
module ahpc_regs_tb;
  logic ref_clk, reset_n, reg_wr, reg_rd, reg_hit, h;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  ahpc_pkg::ahpc_coef_t co [6];
  logic [7:0] dflt [6] = '{`AHPC_RST_NUM0_HI, `AHPC_RST_NUM0_LO, `AHPC_RST_NUM1_HI,
    `AHPC_RST_NUM1_LO, `AHPC_RST_DEN1_HI, `AHPC_RST_DEN1_LO};
  int exp [12];
  int n_errors, total_checks, cyc;
  ahpc_ctrl_model m (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  ahpc_regs dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .left_first_numerator_coef(co[0]), .left_second_numerator_coef(co[1]),
    .left_denominator_coef(co[2]), .right_first_numerator_coef(co[3]),
    .right_second_numerator_coef(co[4]), .right_denominator_coef(co[5]));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(string nm, logic [15:0] seen, logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic load_dflt();
    for (int i = 0; i < 12; i++) exp[i] = dflt[i % 6];
  endtask
  task automatic check_all();
    for (int i = 0; i < 12; i++) begin
      m.rd(8'(`AHPC_COEF_FIRST + i), d, h);
      check("rdata", 16'(d), 16'(exp[i]));
      check("hit", 16'(h), 16'h0001);
    end
    for (int c = 0; c < 6; c++) begin
      check("coef", co[c], {8'(exp[2 * c]), 8'(exp[2 * c + 1])});
    end
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    reset_n = 1'b0;
    void'($urandom(26209));
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    load_dflt();
    check_all();
    $display("test defaults done");
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 12; i++) begin
        d = (r == 2) ? 8'($urandom) : (i % 2 == 1 ? {8{r == 0}} : {r == 1, {7{r == 0}}});
        m.wr(8'(`AHPC_COEF_FIRST + i), d);
        exp[i] = d;
      end
      check_all();
    end
    $display("test write readback done");
    for (int a = 8'h36; a <= 8'h4D; a++) begin
      if (a == `AHPC_COEF_FIRST) a = `AHPC_COEF_LAST + 1;
      m.rd(8'(a), d, h);
      check("rsvd data", 16'(d), 16'(`AHPC_RSVD_VALUE));
      check("rsvd hit", 16'(h), 16'(a >= 8'h37 && a <= 8'h40));
    end
    $display("test reserved done");
    m.wr(8'h36, 8'hA5);
    m.wr(8'h4D, 8'h5A);
    check_all();
    exp[0] = $urandom_range(255, 0);
    m.wr_rd(`AHPC_L_NUM0_HI, 8'(exp[0]), d);
    check("wr rd", 16'(d), 16'(exp[0]));
    $display("test stray write and read back done");
    @(negedge ref_clk);
    reset_n = 1'b0;
    @(negedge ref_clk);
    reset_n = 1'b1;
    load_dflt();
    check_all();
    $display("test reset done");
    stop_test();
  end
endmodule
